// ==== core/crs_pkg.sv ====
package crs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  // a silent fast oscillator is declared failed after this long
  localparam int OSC_FAIL_NS   = 2000;
  localparam logic [7:0] OSC_FAIL_CYC =
    8'(OSC_FAIL_NS / CLK_PERIOD_NS);
  // reset stretch, at least the minimum pin pulse
  localparam int RST_PULSE_NS  = 20000;
  localparam logic [11:0] RST_HOLD_CYC =
    12'((RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // pin ignored briefly after release, covers our own drive echo
  localparam logic [2:0] PIN_GUARD_CYC = 3'h4;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] ADR_CLK_CTL   = 32'h4002_1000;
  localparam logic [31:0] ADR_CLK_CFG   = 32'h4002_1004;
  localparam logic [31:0] ADR_CLK_INT   = 32'h4002_1008;
  localparam logic [31:0] ADR_BKP_CTL   = 32'h4002_1020;
  localparam logic [31:0] ADR_RST_CAUSE = 32'h4002_1024;
  localparam logic [31:0] ADR_PWR_CTL   = 32'h4000_7000;
  localparam logic [31:0] ADR_PWR_STS   = 32'h4000_7004;

  localparam int CTL_FAST_EN  = 16;
  localparam int CTL_FAST_BYP = 18;
  localparam int CTL_MON_EN   = 19;
  localparam int CTL_PLL_EN   = 24;
  localparam int CFG_SYS_SEL  = 0;
  localparam int CFG_SYS_STS  = 2;
  localparam int CFG_PLL_SRC  = 16;
  localparam int CFG_CKO_SEL  = 24;
  localparam int INT_FAIL_FLG = 7;
  localparam int INT_FAIL_CLR = 23;
  localparam int BKP_SLOW_EN  = 0;
  localparam int BKP_SLOW_BYP = 2;
  localparam int BKP_RTC_SEL  = 8;
  localparam int BKP_DOM_RST  = 16;
  localparam int CAUSE_CLR    = 24;
  localparam int CAUSE_LSB    = 26;
  localparam int PWR_LVD_EN   = 4;
  localparam int PWR_LVD_THR  = 5;
  localparam int PWR_LVD_RISE = 8;
  localparam int PWR_LVD_FALL = 9;
  localparam int STS_LVD_FLG  = 2;
  localparam int STS_LVD_PEND = 3;

  // cause flag positions, bit 0 lands on CAUSE_LSB
  localparam int CS_PIN = 0;
  localparam int CS_POR = 1;

  // synchroniser lanes
  localparam int SY_OSC  = 0;
  localparam int SY_XTAL = 1;
  localparam int SY_SPIN = 2;
  localparam int SY_SXT  = 3;
  localparam int SY_SYS  = 4;
  localparam int SY_RC   = 5;
  localparam int SY_PLL  = 6;
  localparam int SY_RESET_PIN_N = 7;
  localparam int SY_SUP  = 8;
  localparam int SY_LVD  = 10;

  typedef enum logic [1:0] {
    CRS_SYS_RC   = 2'b00,
    CRS_SYS_FAST = 2'b01,
    CRS_SYS_PLL  = 2'b10
  } crs_sys_t;

  typedef enum logic [1:0] {
    CRS_SW_FOLLOW = 2'b00,
    CRS_SW_OLD    = 2'b01,
    CRS_SW_NEW    = 2'b10
  } crs_sw_st_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } crs_bus_t;

  typedef struct packed {
    logic lowpwr;
    logic wwdg;
    logic iwdg;
    logic sw;
  } crs_rst_req_t;

  typedef struct packed {
    crs_sw_st_t st;
    logic       on;
    logic [1:0] idx;
    logic       new_prev;
    logic       out;
  } crs_sw_t;

  typedef struct packed {
    logic [17:0] sy1;
    logic [17:0] sy2;
    logic        fast_en;
    logic        fast_byp;
    logic        mon_en;
    logic        pll_en;
    logic        pll_src;
    crs_sys_t    sys_sel;
    logic [2:0]  cko_sel;
    logic        fail_flag;
    logic        slow_en;
    logic        slow_byp;
    logic [1:0]  rtc_sel;
    logic        bkp_rst;
    logic        lvd_en;
    logic [2:0]  lvd_thr;
    logic        lvd_rise;
    logic        lvd_fall;
    logic        lvd_prev;
    logic        lvd_pend;
    logic        lvd_irq;
    logic [5:0]  cause;
    logic        fast_prev;
    logic [7:0]  mon_cnt;
    logic        pll_prev;
    logic        pll_half;
    logic [11:0] rst_cnt;
    logic [2:0]  guard;
    logic        pwr_act;
    logic        sys_act;
    logic [31:0] rdata;
  } crs_core_t;

endpackage

// ==== core/crs_ckout_switch.sv ====
`timescale 1ns/1ps
module crs_ckout_switch
  import crs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] src,
  input  wire logic [2:0] sel,
  output logic            clk_out
);

  crs_sw_t r;
  crs_sw_t n;
  logic    want_on;
  logic    cur_lvl;
  logic    new_lvl;
  logic    differ;

  // ****************************************
  // glitch-free source change
  // ****************************************
  // the old source is let finish its high phase, the output then
  // rests low until the new source falls, so no runt pulse appears
  assign want_on = sel[2];
  assign cur_lvl = r.on & src[r.idx];
  assign new_lvl = want_on & src[sel[1:0]];
  assign differ  = (want_on != r.on) | (want_on & (sel[1:0] != r.idx));

  always_comb begin
    n = r;
    n.new_prev = new_lvl;
    n.out = cur_lvl;
    case (r.st)
      CRS_SW_FOLLOW: begin
        if (differ) n.st = CRS_SW_OLD;
      end
      CRS_SW_OLD: begin
        if (!cur_lvl) begin // R21
          n.on = 1'b0;
          n.out = 1'b0;
          n.st = want_on ? CRS_SW_NEW : CRS_SW_FOLLOW;
        end
      end
      CRS_SW_NEW: begin
        n.out = 1'b0;
        if (!want_on) begin
          n.st = CRS_SW_FOLLOW;
        end else if (r.new_prev && !new_lvl) begin // R21
          n.on = 1'b1;
          n.idx = sel[1:0];
          n.st = CRS_SW_FOLLOW;
        end
      end
      default: n.st = CRS_SW_FOLLOW;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) r <= '0;
    else r <= n;
  end

  assign clk_out = r.out;

  AST_CKO_QUIET: assert property (@(posedge sys_clk) // R21
    disable iff (!rst_b) (r.st == CRS_SW_NEW) |=> !clk_out)
    else $error("clock output not quiet while waiting for new source");

endmodule

// ==== core/crs_supervisor.sv ====
// Behaviour
// R01 - fast bypass bit takes the fast clock straight from the oscillator pin
// R02 - slow bypass bit takes the slow clock straight from its input pin
// R03 - 3-bit clock output select; top bit clear gives no clock
// R04 - software enables the monitor only after fast oscillator start-up
// R05 - a detected fast oscillator failure switches that oscillator off
// R06 - a failure sets the oscillator-failure flag and raises an event
// R07 - the failure interrupt goes to the non-maskable interrupt
// R08 - failure while fast clock feeds system clock falls back to RC
// R09 - failure while fast clock feeds the PLL switches the PLL off
// R10 - software reselects the real-time clock source after a failure
// R11 - power, system and backup resets; power spares the backup domain
// R12 - reset pin is driven low through any power or system reset
// R13 - supply below threshold forces a power reset
// R14 - low-voltage detection only when enabled, threshold from 3-bit field
// R15 - low-voltage event shows in status and on interrupt line 16
// R16 - line 16 interrupt on rising, falling or both edges as configured
// R17 - reset causes held in cause register; only power reset clears them
// R18 - writing the clear bit wipes all reset-cause flags
// R19 - an external source holds the reset pin low at least 20 us
// R20 - one sticky flag per reset source until cleared
// R21 - clock output changes source without truncated pulses
`timescale 1ns/1ps
module crs_supervisor
  import crs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  crs_bus_t        bus_req,
  output logic [31:0]     bus_rdata,
  input  wire logic       osc_input_pin,
  input  wire logic       fast_xtal_clk,
  output logic            fast_osc_amp_en,
  output logic            fast_ext_clock,
  input  wire logic       slow_osc_input_pin,
  input  wire logic       slow_xtal_clk,
  output logic            slow_osc_amp_en,
  output logic            slow_ext_clock,
  input  wire logic       system_clock,
  input  wire logic       internal_rc_clock,
  input  wire logic       pll_clock,
  output logic            pll_en,
  output logic            pll_src_fast,
  output crs_sys_t        sys_clk_sel,
  output logic [1:0]      rtc_clk_sel,
  output logic            clock_out,
  output logic            osc_fail_nmi,
  input  wire logic       supply_low,
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe,
  output logic            power_reset_b,
  output logic            system_reset_b,
  output logic            backup_reset_b,
  input  crs_rst_req_t    rst_req,
  input  wire logic [7:0] lvd_cmp,
  output logic [2:0]      low_volt_threshold,
  output logic            low_volt_detect_en,
  output logic            lvd_line16,
  output logic            lvd_irq_line16
);

  crs_core_t  r;
  crs_core_t  n;
  logic       fclk;
  logic       mon_on;
  logic       osc_fail;
  logic       lvd_lvl;
  logic       in_rst;
  logic [5:0] src;
  logic [2:0] dsel;
  logic [7:0] taps;

  // ****************************************
  // address decode
  // ****************************************
  // shared by the write and the read path; 0 means unmapped
  function automatic logic [2:0] crs_decode(input logic [31:0] a);
    case (a)
      ADR_CLK_CTL:   crs_decode = 3'h1;
      ADR_CLK_CFG:   crs_decode = 3'h2;
      ADR_CLK_INT:   crs_decode = 3'h3;
      ADR_BKP_CTL:   crs_decode = 3'h4;
      ADR_RST_CAUSE: crs_decode = 3'h5;
      ADR_PWR_CTL:   crs_decode = 3'h6;
      ADR_PWR_STS:   crs_decode = 3'h7;
      default:       crs_decode = 3'h0;
    endcase
  endfunction

  // ****************************************
  // derived levels
  // ****************************************
  // only the second synchroniser stage is looked at
  assign fclk = r.fast_byp ? r.sy2[SY_OSC] : r.sy2[SY_XTAL]; // R01
  assign mon_on = r.mon_en & r.fast_en;
  // no edge for the whole window while monitored: oscillator is dead
  assign osc_fail = mon_on & (fclk == r.fast_prev) &
                    (r.mon_cnt == OSC_FAIL_CYC - 8'h01);
  assign taps = r.sy2[SY_LVD +: 8];
  assign lvd_lvl = r.lvd_en & taps[r.lvd_thr]; // R14
  assign in_rst = r.pwr_act | r.sys_act;
  assign dsel = crs_decode(bus_req.addr);
  // pin counts as a cause only when we are not the one pulling it
  assign src = {rst_req.lowpwr, rst_req.wwdg, rst_req.iwdg, rst_req.sw,
                1'b0,
                ~r.sy2[SY_RESET_PIN_N] & (r.guard == 3'h0) & ~in_rst}; // R20

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    n.sy1 = {lvd_cmp, 1'b0, supply_low, reset_pin_in, pll_clock,
             internal_rc_clock, system_clock, slow_xtal_clk,
             slow_osc_input_pin, fast_xtal_clk, osc_input_pin};
    n.sy2 = r.sy1;
    n.bkp_rst = 1'b0;

    // software writes; ignored while the core is held in reset
    if (bus_req.wr && !in_rst) begin
      case (dsel)
        3'h1: begin
          n.fast_en  = bus_req.wdata[CTL_FAST_EN];
          n.fast_byp = bus_req.wdata[CTL_FAST_BYP]; // R01
          n.mon_en   = bus_req.wdata[CTL_MON_EN];
          n.pll_en   = bus_req.wdata[CTL_PLL_EN];
        end
        3'h2: begin
          // the unused encoding keeps the current source
          if (bus_req.wdata[CFG_SYS_SEL +: 2] != 2'b11)
            n.sys_sel = crs_sys_t'(bus_req.wdata[CFG_SYS_SEL +: 2]);
          n.pll_src = bus_req.wdata[CFG_PLL_SRC];
          n.cko_sel = bus_req.wdata[CFG_CKO_SEL +: 3]; // R03
        end
        3'h3: begin
          if (bus_req.wdata[INT_FAIL_CLR]) n.fail_flag = 1'b0;
        end
        3'h4: begin
          n.slow_en  = bus_req.wdata[BKP_SLOW_EN];
          n.slow_byp = bus_req.wdata[BKP_SLOW_BYP]; // R02
          n.rtc_sel  = bus_req.wdata[BKP_RTC_SEL +: 2];
          if (bus_req.wdata[BKP_DOM_RST]) begin // R11
            n.slow_en  = 1'b0;
            n.slow_byp = 1'b0;
            n.rtc_sel  = 2'b00;
            n.bkp_rst  = 1'b1;
          end
        end
        3'h5: begin
          if (bus_req.wdata[CAUSE_CLR]) n.cause = 6'h00; // R18
        end
        3'h6: begin
          n.lvd_en   = bus_req.wdata[PWR_LVD_EN]; // R14
          n.lvd_thr  = bus_req.wdata[PWR_LVD_THR +: 3];
          n.lvd_rise = bus_req.wdata[PWR_LVD_RISE];
          n.lvd_fall = bus_req.wdata[PWR_LVD_FALL];
        end
        3'h7: begin
          if (bus_req.wdata[STS_LVD_PEND]) n.lvd_pend = 1'b0;
        end
        default: n.lvd_pend = n.lvd_pend;
      endcase
    end

    // fast oscillator monitor; software is trusted to enable it only
    // once the oscillator has started, else start-up looks like a fault
    n.fast_prev = fclk; // R04
    if (!mon_on || fclk != r.fast_prev) n.mon_cnt = 8'h00;
    else n.mon_cnt = r.mon_cnt + 8'h01;
    if (osc_fail) begin
      n.fast_en = 1'b0; // R05
      n.fail_flag = 1'b1; // R06
      if (r.sys_sel == CRS_SYS_FAST ||
          (r.sys_sel == CRS_SYS_PLL && r.pll_src))
        n.sys_sel = CRS_SYS_RC; // R08
      if (r.pll_src) n.pll_en = 1'b0; // R09
      // the real-time clock selection is left alone on purpose
    end

    // pll divided by two on rising edges of the sampled pll clock
    n.pll_prev = r.sy2[SY_PLL];
    if (r.sy2[SY_PLL] && !r.pll_prev) n.pll_half = ~r.pll_half;

    // low-voltage level, edge interrupt for line 16
    n.lvd_prev = lvd_lvl; // R15
    n.lvd_irq = (lvd_lvl & ~r.lvd_prev & r.lvd_rise) |
                (~lvd_lvl & r.lvd_prev & r.lvd_fall); // R16
    if (n.lvd_irq) n.lvd_pend = 1'b1;

    // reset sequencer: stretch, then release with a pin guard
    if (r.guard != 3'h0) n.guard = r.guard - 3'h1;
    if (in_rst) begin
      if (r.rst_cnt != 12'h000) begin
        n.rst_cnt = r.rst_cnt - 12'h001;
      end else begin
        n.pwr_act = 1'b0;
        n.sys_act = 1'b0;
        n.guard = PIN_GUARD_CYC;
      end
    end
    if (|src && !r.pwr_act) begin
      n.sys_act = 1'b1;
      n.rst_cnt = RST_HOLD_CYC;
      n.cause = n.cause | src; // R20
    end
    // a low supply keeps reloading the stretch until it recovers
    if (r.sy2[SY_SUP]) begin
      n.pwr_act = 1'b1; // R13
      n.rst_cnt = RST_HOLD_CYC;
    end
    if (r.pwr_act) begin
      n.cause = 6'h00; // R17
      n.cause[CS_POR] = 1'b1;
    end

    // a power or system reset returns the non-backup controls to their defaults
    if (in_rst) begin // R11
      n.fast_en   = 1'b0;
      n.fast_byp  = 1'b0;
      n.mon_en    = 1'b0;
      n.pll_en    = 1'b0;
      n.pll_src   = 1'b0;
      n.sys_sel   = CRS_SYS_RC;
      n.cko_sel   = 3'h0;
      n.fail_flag = 1'b0;
      n.lvd_en    = 1'b0;
      n.lvd_thr   = 3'h0;
      n.lvd_rise  = 1'b0;
      n.lvd_fall  = 1'b0;
      n.lvd_pend  = 1'b0;
    end

    // read data stand only in the cycle after the strobe
    n.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      case (dsel)
        3'h1: begin
          n.rdata[CTL_FAST_EN]  = r.fast_en;
          n.rdata[CTL_FAST_BYP] = r.fast_byp;
          n.rdata[CTL_MON_EN]   = r.mon_en;
          n.rdata[CTL_PLL_EN]   = r.pll_en;
        end
        3'h2: begin
          n.rdata[CFG_SYS_SEL +: 2] = r.sys_sel;
          n.rdata[CFG_SYS_STS +: 2] = r.sys_sel;
          n.rdata[CFG_PLL_SRC]      = r.pll_src;
          n.rdata[CFG_CKO_SEL +: 3] = r.cko_sel;
        end
        3'h3: n.rdata[INT_FAIL_FLG] = r.fail_flag;
        3'h4: begin
          n.rdata[BKP_SLOW_EN]      = r.slow_en;
          n.rdata[BKP_SLOW_BYP]     = r.slow_byp;
          n.rdata[BKP_RTC_SEL +: 2] = r.rtc_sel;
        end
        3'h5: n.rdata[CAUSE_LSB +: 6] = r.cause; // R17
        3'h6: begin
          n.rdata[PWR_LVD_EN]       = r.lvd_en;
          n.rdata[PWR_LVD_THR +: 3] = r.lvd_thr;
          n.rdata[PWR_LVD_RISE]     = r.lvd_rise;
          n.rdata[PWR_LVD_FALL]     = r.lvd_fall;
        end
        3'h7: begin
          n.rdata[STS_LVD_FLG]  = r.lvd_prev; // R15
          n.rdata[STS_LVD_PEND] = r.lvd_pend;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // block reset starts a full power-on sequence after release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.pwr_act <= 1'b1;
      r.rst_cnt <= RST_HOLD_CYC;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // clock output
  // ****************************************
  // sources are sampled at sys_clk, so only clocks well below half
  // of sys_clk come out with a faithful shape
  crs_ckout_switch u_ckout (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .src     ({r.pll_half, fclk, r.sy2[SY_RC], r.sy2[SY_SYS]}), // R03
    .sel     (r.cko_sel),
    .clk_out (clock_out)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign bus_rdata          = r.rdata;
  assign fast_osc_amp_en    = r.fast_en & ~r.fast_byp; // R01
  assign fast_ext_clock     = r.fast_en & fclk;
  assign slow_osc_amp_en    = r.slow_en & ~r.slow_byp; // R02
  assign slow_ext_clock     = r.slow_en &
    (r.slow_byp ? r.sy2[SY_SPIN] : r.sy2[SY_SXT]); // R02
  assign pll_en             = r.pll_en;
  assign pll_src_fast       = r.pll_src;
  assign sys_clk_sel        = r.sys_sel;
  assign rtc_clk_sel        = r.rtc_sel; // R10
  assign osc_fail_nmi       = r.fail_flag; // R07
  assign reset_pin_out      = 1'b0; // R12
  assign reset_pin_oe       = in_rst; // R12
  assign power_reset_b      = ~r.pwr_act;
  assign system_reset_b     = ~in_rst;
  assign backup_reset_b     = ~r.bkp_rst;
  assign low_volt_threshold = r.lvd_thr;
  assign low_volt_detect_en = r.lvd_en;
  assign lvd_line16         = r.lvd_prev; // R15
  assign lvd_irq_line16     = r.lvd_irq; // R16

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_FAIL_OFF: assert property ( // R05
    osc_fail && !in_rst |=> !r.fast_en && !fast_osc_amp_en)
    else $error("fast oscillator left on after failure");

  AST_FAIL_FLAG: assert property ( // R06
    osc_fail && !in_rst |=> r.fail_flag [*2])
    else $error("failure flag not set");

  AST_FAIL_NMI: assert property ( // R07
    $rose(r.fail_flag) |-> osc_fail_nmi && $past(osc_fail))
    else $error("nmi without a detected failure");

  AST_FALLBACK: assert property ( // R08
    osc_fail && !in_rst && (r.sys_sel == CRS_SYS_FAST ||
      (r.sys_sel == CRS_SYS_PLL && r.pll_src))
    |=> sys_clk_sel == CRS_SYS_RC)
    else $error("system clock not moved to rc");

  AST_PLL_OFF: assert property ( // R09
    osc_fail && r.pll_src |=> !pll_en)
    else $error("pll left on after failure");

  AST_PIN_LOW: assert property ( // R12
    r.sy2[SY_SUP] |=> reset_pin_oe && !reset_pin_out && !power_reset_b
      ##1 reset_pin_oe)
    else $error("reset pin not driven during power reset");

  AST_RST_HOLD: assert property ( // R13
    $fell(power_reset_b) |-> !power_reset_b [*8])
    else $error("power reset released too early");

  AST_LVD_OFF: assert property ( // R14
    !r.lvd_en |=> !lvd_line16 ##1 (!lvd_irq_line16 || $past(r.lvd_en)))
    else $error("low-voltage seen while detector off");

  AST_LVD_RISE: assert property ( // R16
    lvd_lvl && !r.lvd_prev && r.lvd_rise |=> lvd_irq_line16 && lvd_line16)
    else $error("missing rising-edge line 16 interrupt");

  AST_CAUSE_CLR: assert property ( // R18
    bus_req.wr && dsel == 3'h5 && bus_req.wdata[CAUSE_CLR] &&
      !in_rst && src == 6'h00 && !r.sy2[SY_SUP] |=> r.cause == 6'h00)
    else $error("reset causes not cleared");

  AST_CAUSE_STAY: assert property ( // R20
    r.cause[CS_PIN] && !r.pwr_act && !(bus_req.wr && dsel == 3'h5)
    |=> r.cause[CS_PIN])
    else $error("pin cause flag lost");

endmodule

// ==== tb/crs_src_model.sv ====
`timescale 1ns/1ps
module crs_src_model (
  input  wire logic fast_run,
  input  wire logic pin_low,
  input  wire logic reset_pin_oe,
  output logic      osc_input_pin,
  output logic      fast_xtal_clk,
  output logic      slow_osc_input_pin,
  output logic      slow_xtal_clk,
  output logic      system_clock,
  output logic      internal_rc_clock,
  output logic      pll_clock,
  output logic      reset_pin_in
);
  // ****
  // clock sources
  // ****
  // distinct rates so the source seen at the far end can be told apart
  initial begin
    {osc_input_pin, fast_xtal_clk, slow_osc_input_pin} = '0;
    {slow_xtal_clk, system_clock, internal_rc_clock, pll_clock} = '0;
  end
  // fast sources freeze when stopped, as a dead oscillator does
  always #160 if (fast_run) osc_input_pin = ~osc_input_pin;
  always #24 if (fast_run) fast_xtal_clk = ~fast_xtal_clk;
  always #800 slow_osc_input_pin = ~slow_osc_input_pin;
  always #200 slow_xtal_clk = ~slow_xtal_clk;
  always #40 system_clock = ~system_clock;
  always #80 internal_rc_clock = ~internal_rc_clock;
  always #32 pll_clock = ~pll_clock;
  // ****
  // reset pin
  // ****
  // open drain with pull-up: low while either side pulls it
  assign reset_pin_in = ~(reset_pin_oe | pin_low);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import crs_pkg::*;
  // ****
  // signals
  // ****
  logic         sys_clk, rst_b, supply_low, fast_run, pin_low;
  crs_bus_t     bus_req;
  crs_rst_req_t rst_req;
  logic [7:0]   lvd_cmp;
  logic [31:0]  bus_rdata, ex;
  crs_sys_t     sys_clk_sel;
  logic [1:0]   rtc_clk_sel;
  logic [2:0]   low_volt_threshold;
  logic         osc_input_pin, fast_xtal_clk, slow_osc_input_pin;
  logic         slow_xtal_clk, system_clock, internal_rc_clock;
  logic         pll_clock, reset_pin_in, reset_pin_oe, pll_en;
  logic         slow_ext_clock, clock_out, osc_fail_nmi;
  logic         power_reset_b, system_reset_b, low_volt_detect_en;
  logic         lvd_line16, lvd_irq_line16, fast_osc_amp_en;
  logic         slow_osc_amp_en, backup_reset_b, reset_pin_out;
  logic         pll_src_fast, fast_ext_clock;
  int           errors, checked, cyc, n_co, n_sl, n_irq;
  int           ex_co[8] = '{0, 0, 0, 0, 80, 40, 20, 50};

  crs_supervisor i_dut (
    .sys_clk, .rst_b, .bus_req, .bus_rdata, .osc_input_pin,
    .fast_xtal_clk, .fast_osc_amp_en, .fast_ext_clock,
    .slow_osc_input_pin, .slow_xtal_clk, .slow_osc_amp_en,
    .slow_ext_clock, .system_clock, .internal_rc_clock, .pll_clock,
    .pll_en, .pll_src_fast, .sys_clk_sel, .rtc_clk_sel, .clock_out,
    .osc_fail_nmi, .supply_low, .reset_pin_in, .reset_pin_out,
    .reset_pin_oe, .power_reset_b, .system_reset_b, .backup_reset_b,
    .rst_req, .lvd_cmp, .low_volt_threshold, .low_volt_detect_en,
    .lvd_line16, .lvd_irq_line16
  );
  crs_src_model i_src (
    .fast_run, .pin_low, .reset_pin_oe, .osc_input_pin, .fast_xtal_clk,
    .slow_osc_input_pin, .slow_xtal_clk, .system_clock,
    .internal_rc_clock, .pll_clock, .reset_pin_in
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // edge counters; a window of 800 cycles is 6400 ns
  always @(posedge clock_out) n_co++;
  always @(posedge slow_ext_clock) n_sl++;
  always @(posedge sys_clk) begin
    if (lvd_irq_line16 === 1'b1) n_irq++;
    cyc++;
    if (cyc == 50000) begin
      errors++;
      complete_run;
    end
  end
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus_req <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge sys_clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk) bus_req <= '0;
    #1 chk(bus_rdata, e);
  endtask
  task wait_c(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task win;
    wait_c(100);
    n_co = 0;
    n_sl = 0;
    wait_c(800);
  endtask
  // phase of an async source moves the count by a few edges
  task rng(input int n, input int e);
    int t;
    t = (e + 15) / 16;
    chk(32'(n), (n >= e - t && n <= e + t) ? 32'(n) : 32'(e));
  endtask
  task wrel;
    for (int i = 0; i < 4000 && system_reset_b !== 1'b1; i++)
      @(posedge sys_clk);
    wait_c(2);
  endtask
  task complete_run;
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    {rst_b, supply_low, pin_low, fast_run} = 4'h1;
    {bus_req, rst_req, lvd_cmp} = '0;
    {errors, checked, cyc, n_co, n_sl, n_irq} = '0;
    wait_c(8);
    rst_b <= 1'b1;
    wait_c(2);
    chk({power_reset_b, reset_pin_oe}, 32'h1);
    wrel;
    chk({power_reset_b, reset_pin_oe}, 32'h2);
    rd(ADR_RST_CAUSE, 32'h0800_0000);
    rd(32'h4002_1010, 32'h0);
    // failure while the fast clock feeds the pll that runs the system
    wr(ADR_BKP_CTL, 32'h0000_0200);
    wr(ADR_CLK_CFG, 32'h0001_0002);
    wr(ADR_CLK_CTL, 32'h0105_0000);
    wait_c(50);
    wr(ADR_CLK_CTL, 32'h010d_0000);
    wait_c(300);
    fast_run <= 1'b0;
    wait_c(225);
    chk(osc_fail_nmi, 32'h0);
    for (int i = 0; i < 40 && osc_fail_nmi !== 1'b1; i++)
      @(posedge sys_clk);
    #1 chk(osc_fail_nmi, 32'h1);
    chk({fast_ext_clock, pll_en, sys_clk_sel}, {2'b00, CRS_SYS_RC});
    chk(rtc_clk_sel, 32'h2);
    rd(ADR_CLK_CTL, 32'h000c_0000);
    rd(ADR_CLK_INT, 32'h0000_0080);
    wr(ADR_CLK_INT, 32'h0080_0000);
    wr(ADR_CLK_CTL, 32'h0004_0000);
    fast_run <= 1'b1;
    rd(ADR_CLK_INT, 32'h0);
    chk(osc_fail_nmi, 32'h0);
    // every clock output code, fast clock from the bypass pin
    wr(ADR_CLK_CTL, 32'h0005_0000);
    for (int c = 0; c < 8; c++) begin
      wr(ADR_CLK_CFG, 32'(c) << 24);
      win;
      rng(n_co, ex_co[c]);
    end
    wr(ADR_CLK_CTL, 32'h0001_0000);
    #1 chk({fast_osc_amp_en, pll_src_fast, reset_pin_out}, 32'h4);
    wr(ADR_CLK_CFG, 32'h0600_0000);
    win;
    rng(n_co, 133);
    wr(ADR_BKP_CTL, 32'h0000_0005);
    #1 chk(slow_osc_amp_en, 32'h0);
    win;
    rng(n_sl, 4);
    wr(ADR_BKP_CTL, 32'h0000_0001);
    #1 chk(slow_osc_amp_en, 32'h1);
    win;
    rng(n_sl, 16);
    // low-voltage detect, tap 3, both edges then rising only
    wr(ADR_PWR_CTL, 32'h0000_0370);
    #1 chk({low_volt_detect_en, low_volt_threshold}, 32'hb);
    lvd_cmp <= 8'h04;
    wait_c(8);
    chk(n_irq, 32'h0);
    lvd_cmp <= 8'h0c;
    wait_c(8);
    chk({n_irq[3:0], lvd_line16}, 32'h3);
    rd(ADR_PWR_STS, 32'h0000_000c);
    lvd_cmp <= 8'h00;
    wait_c(8);
    chk(n_irq, 32'h2);
    wr(ADR_PWR_CTL, 32'h0000_0170);
    lvd_cmp <= 8'h08;
    wait_c(8);
    lvd_cmp <= 8'h00;
    wait_c(8);
    chk(n_irq, 32'h3);
    wr(ADR_PWR_STS, 32'h0000_0008);
    rd(ADR_PWR_STS, 32'h0);
    // each requested reset adds its own sticky cause
    ex = 32'h0800_0000;
    for (int k = 0; k < 4; k++) begin
      rst_req <= 4'(1 << k);
      wait_c(1);
      rst_req <= '0;
      #1 chk({system_reset_b, reset_pin_oe}, 32'h1);
      wrel;
      ex = ex | (32'h1000_0000 << k);
      rd(ADR_RST_CAUSE, ex);
    end
    rd(ADR_PWR_CTL, 32'h0);
    rd(ADR_BKP_CTL, 32'h0000_0001);
    wr(ADR_RST_CAUSE, 32'h0100_0000);
    rd(ADR_RST_CAUSE, 32'h0);
    pin_low <= 1'b1;
    wait_c(2500);
    pin_low <= 1'b0;
    wrel;
    rd(ADR_RST_CAUSE, 32'h0400_0000);
    supply_low <= 1'b1;
    wait_c(10);
    chk(power_reset_b, 32'h0);
    supply_low <= 1'b0;
    wrel;
    rd(ADR_RST_CAUSE, 32'h0800_0000);
    rd(ADR_BKP_CTL, 32'h0000_0001);
    wr(ADR_BKP_CTL, 32'h0001_0001);
    #1 chk(backup_reset_b, 32'h0);
    rd(ADR_BKP_CTL, 32'h0);
    chk(backup_reset_b, 32'h1);
    complete_run;
  end
endmodule
